// [pkg/aer_vc_pkg.sv]
// Package: offsets, fields, reset values and carriers for the error/channel capability bank
package aer_vc_pkg;
  localparam logic [11:0] OFF_ERR_CAP_CTRL = 12'h118;
  localparam logic [11:0] OFF_HDR_WORD0 = 12'h11C;
  localparam logic [11:0] OFF_HDR_WORD1 = 12'h120;
  localparam logic [11:0] OFF_HDR_WORD2 = 12'h124;
  localparam logic [11:0] OFF_HDR_WORD3 = 12'h128;
  localparam logic [11:0] OFF_CHAN_CAP_HDR = 12'h140;
  localparam logic [11:0] OFF_PORT_CHAN_CAP1 = 12'h144;
  localparam logic [11:0] OFF_PORT_CHAN_CAP2 = 12'h148;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h160;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h164;
  localparam logic [11:0] OFF_LOAD_CTRL = 12'h168;

  localparam int FEP_LSB = 0;
  localparam int ECRC_GEN_CAP_BIT = 5;
  localparam int ECRC_GEN_EN_BIT = 6;
  localparam int ECRC_CHK_CAP_BIT = 7;
  localparam int ECRC_CHK_EN_BIT = 8;
  localparam logic [4:0] FEP_RESET = 5'h00;
  localparam logic ECRC_GEN_CAP_VAL = 1'b1;
  localparam logic ECRC_CHK_CAP_VAL = 1'b1;

  localparam logic [15:0] CHAN_CAP_ID = 16'h0002;
  localparam logic [3:0] CHAN_CAP_VER = 4'h1;
  localparam logic [11:0] CHAN_NEXT_PTR = 12'h20C;

  localparam logic [1:0] EXT_COUNT_UPPER_RESET = 2'h0;
  localparam logic [2:0] LOW_PRIO_COUNT_RESET = 3'h0;
  localparam logic [1:0] REF_CLOCK_100NS = 2'h0;
  localparam logic [1:0] TABLE_ENTRY_4BIT = 2'h2;
  localparam logic [7:0] ARB_CAP_WITH_CH = 8'h03;
  localparam logic [7:0] ARB_CAP_NO_CH = 8'h00;
  localparam logic [7:0] ARB_OFF_WITH_CH = 8'h03;
  localparam logic [7:0] ARB_OFF_NO_CH = 8'h00;

  localparam int IRQ_HDR_CAPTURED = 0;
  localparam int IRQ_HDR_DROPPED = 1;
  localparam int IRQ_BITS = 2;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  typedef struct packed {
    logic [4:0] first_error;
    logic gen_en;
    logic chk_en;
    logic [3:0][31:0] header;
    logic header_valid;
  } sticky_s;

  typedef struct packed {
    logic [2:0] ext_count;
    logic [2:0] low_priority_channel_count;
    logic [7:0] arb_cap;
    logic [7:0] arb_offset;
  } chan_cap_s;

  typedef struct packed {
    logic valid;
    logic [4:0] bit_index;
    logic masked;
    logic [3:0][31:0] header;
  } err_event_s;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage : aer_vc_pkg

// [verilog/aer_ecrc_channel_capability_header_regs.sv]
// Error capability, header capture and channel capability register bank
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
//------------------------------------------------------------
// Behaviour
// - Five-bit sticky read-only first error index, zero after reset.
// - Bit five reads one: end-to-end CRC generation capable.
// - Sticky writable generate enable at bit six, drives CRC append, resets zero.
// - Read-only check capable bit reads one.
// - Sticky writable check enable at bit eight, drives CRC checking, resets zero.
// - Four sticky read-only header words capture the erroring packet header, big-endian.
// - Channel header reads identifier 0002h and version 1h.
// - Next pointer in bits 31:20 reads 20Ch.
// - Extended count resets to 00b plus strap bit; autoload may override.
// - Low-priority count in bits 6:4 resets 000b; autoload may override.
// - Reference clock field bits 9:8 reads 00b, 100 ns base.
// - Bits 11:10 read 10b, four-bit table entries.
// - Arbitration capability resets 03h with strap bit set, else 00h.
// - Arbitration capability meaningful only while low-priority count nonzero.
// - Table offset bits 31:24 in sixteen-byte units, 03h with strap else 00h.
// - Masked errors are neither logged in the header capture nor messaged.
//------------------------------------------------------------
module aer_ecrc_channel_capability_header_regs (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic hot_reset_i,
  input wire logic second_channel_strap_i,
  input wire logic autoload_valid_i,
  input wire aer_vc_pkg::chan_cap_s autoload_i,
  input wire aer_vc_pkg::err_event_s err_event_i,
  input wire aer_vc_pkg::reg_req_s req_i,
  output logic [31:0] rdata_o,
  output logic ecrc_gen_en_o,
  output logic ecrc_chk_en_o,
  output logic err_message_o,
  output logic arb_cap_valid_o,
  output logic irq_o
);

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  typedef struct packed {
    aer_vc_pkg::sticky_s sticky;
    aer_vc_pkg::chan_cap_s chan;
    logic strap_taken;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] rdata;
    logic err_message;
    logic irq;
    logic arb_cap_valid;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  function automatic logic [31:0] read_word(input state_s s, input logic [11:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      aer_vc_pkg::OFF_ERR_CAP_CTRL: begin
        w[aer_vc_pkg::FEP_LSB +: 5] = s.sticky.first_error;
        w[aer_vc_pkg::ECRC_GEN_CAP_BIT] = aer_vc_pkg::ECRC_GEN_CAP_VAL;
        w[aer_vc_pkg::ECRC_GEN_EN_BIT] = s.sticky.gen_en;
        w[aer_vc_pkg::ECRC_CHK_CAP_BIT] = aer_vc_pkg::ECRC_CHK_CAP_VAL;
        w[aer_vc_pkg::ECRC_CHK_EN_BIT] = s.sticky.chk_en;
      end
      aer_vc_pkg::OFF_HDR_WORD0: w = s.sticky.header[0];
      aer_vc_pkg::OFF_HDR_WORD1: w = s.sticky.header[1];
      aer_vc_pkg::OFF_HDR_WORD2: w = s.sticky.header[2];
      aer_vc_pkg::OFF_HDR_WORD3: w = s.sticky.header[3];
      aer_vc_pkg::OFF_CHAN_CAP_HDR: begin
        w = {aer_vc_pkg::CHAN_NEXT_PTR, aer_vc_pkg::CHAN_CAP_VER, aer_vc_pkg::CHAN_CAP_ID};
      end
      aer_vc_pkg::OFF_PORT_CHAN_CAP1: begin
        w = {20'h00000, aer_vc_pkg::TABLE_ENTRY_4BIT, aer_vc_pkg::REF_CLOCK_100NS,
             1'b0, s.chan.low_priority_channel_count, 1'b0, s.chan.ext_count};
      end
      aer_vc_pkg::OFF_PORT_CHAN_CAP2: w = {s.chan.arb_offset, 16'h0000, s.chan.arb_cap};
      aer_vc_pkg::OFF_IRQ_STATUS: w = {30'h00000000, s.irq_status};
      aer_vc_pkg::OFF_IRQ_MASK: w = {30'h00000000, s.irq_mask};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  //------------------------------------------------------------
  // Next state
  //------------------------------------------------------------
  always_comb begin
    logic [1:0] ev;
    logic [1:0] clr;
    state_nxt = state_r;
    ev = 2'h0;
    clr = 2'h0;
    state_nxt.rdata = 32'h0000_0000;
    state_nxt.err_message = 1'b0;
    if (req_i.rd) begin
      state_nxt.rdata = read_word(state_r, req_i.addr);
    end
    if (req_i.wr && req_i.addr == aer_vc_pkg::OFF_ERR_CAP_CTRL) begin
      state_nxt.sticky.gen_en = req_i.wdata[aer_vc_pkg::ECRC_GEN_EN_BIT];
      state_nxt.sticky.chk_en = req_i.wdata[aer_vc_pkg::ECRC_CHK_EN_BIT];
    end
    if (req_i.wr && req_i.addr == aer_vc_pkg::OFF_IRQ_MASK) begin
      state_nxt.irq_mask = req_i.wdata[1:0];
    end
    if (req_i.wr && req_i.addr == aer_vc_pkg::OFF_IRQ_STATUS) begin
      clr = req_i.wdata[1:0];
    end
    if (!state_r.strap_taken) begin
      state_nxt.strap_taken = 1'b1;
      state_nxt.chan.ext_count = {aer_vc_pkg::EXT_COUNT_UPPER_RESET, second_channel_strap_i};
      state_nxt.chan.arb_cap = second_channel_strap_i ? aer_vc_pkg::ARB_CAP_WITH_CH
                                                      : aer_vc_pkg::ARB_CAP_NO_CH;
      state_nxt.chan.arb_offset = second_channel_strap_i ? aer_vc_pkg::ARB_OFF_WITH_CH
                                                         : aer_vc_pkg::ARB_OFF_NO_CH;
    end else if (autoload_valid_i) begin
      state_nxt.chan = autoload_i;
    end
    state_nxt.arb_cap_valid = state_nxt.chan.low_priority_channel_count != 3'h0;
    if (err_event_i.valid) begin
      if (err_event_i.masked) begin
        ev[aer_vc_pkg::IRQ_HDR_DROPPED] = 1'b1;
      end else begin
        state_nxt.err_message = 1'b1;
        if (!state_r.sticky.header_valid) begin
          state_nxt.sticky.first_error = err_event_i.bit_index;
          state_nxt.sticky.header = err_event_i.header;
          state_nxt.sticky.header_valid = 1'b1;
          ev[aer_vc_pkg::IRQ_HDR_CAPTURED] = 1'b1;
        end
      end
    end
    // Set wins over clear
    state_nxt.irq_status = (state_r.irq_status & ~clr) | ev;
    state_nxt.irq = |(state_nxt.irq_status & state_nxt.irq_mask);
    if (hot_reset_i) begin
      state_nxt.irq_status = 2'h0;
      state_nxt.irq_mask = aer_vc_pkg::IRQ_MASK_RESET;
      state_nxt.irq = 1'b0;
      state_nxt.err_message = 1'b0;
      state_nxt.rdata = 32'h0000_0000;
      state_nxt.strap_taken = 1'b0;
    end
  end

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= '0;
      state_r.sticky.first_error <= aer_vc_pkg::FEP_RESET;
      state_r.irq_mask <= aer_vc_pkg::IRQ_MASK_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata_o = state_r.rdata;
  assign ecrc_gen_en_o = state_r.sticky.gen_en;
  assign ecrc_chk_en_o = state_r.sticky.chk_en;
  assign err_message_o = state_r.err_message;
  // capability valid only with low-priority channels
  assign arb_cap_valid_o = state_r.arb_cap_valid;
  assign irq_o = state_r.irq;

  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_gen_cap_one: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_ERR_CAP_CTRL |=>
    rdata_o[aer_vc_pkg::ECRC_GEN_CAP_BIT] && rdata_o[aer_vc_pkg::ECRC_CHK_CAP_BIT])
    else $error("capability bits not one");
  a_chk_cap_one: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_ERR_CAP_CTRL |=>
    rdata_o[aer_vc_pkg::ECRC_CHK_CAP_BIT] && rdata_o[31:9] == 23'h000000) else $error("check capable or reserved wrong");
  a_gen_en_write: assert property (req_i.wr && req_i.addr == aer_vc_pkg::OFF_ERR_CAP_CTRL
    && !hot_reset_i |=> ecrc_gen_en_o == $past(req_i.wdata[6])) else $error("generate enable wrong");
  a_chk_en_write: assert property (req_i.wr && req_i.addr == aer_vc_pkg::OFF_ERR_CAP_CTRL
    && !hot_reset_i |=> ecrc_chk_en_o == $past(req_i.wdata[8])) else $error("check enable wrong");
  a_sticky_hot_reset: assert property (hot_reset_i && !req_i.wr |=> $stable(ecrc_gen_en_o)
    && $stable(ecrc_chk_en_o)) else $error("sticky lost on hot reset");
  a_chan_header: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_CHAN_CAP_HDR |=>
    rdata_o[19:0] == 20'h10002) else $error("channel header id wrong");
  a_next_ptr: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_CHAN_CAP_HDR |=>
    rdata_o[31:20] == 12'h20C) else $error("next pointer wrong");
  a_cap1_fixed: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_PORT_CHAN_CAP1 |=>
    rdata_o[11:8] == 4'h8) else $error("reference clock or entry size wrong");
  a_entry_size: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_PORT_CHAN_CAP1 |=>
    rdata_o[11:10] == 2'h2) else $error("entry size wrong");
  a_masked_no_log: assert property (err_event_i.valid && err_event_i.masked && !hot_reset_i
    |=> !err_message_o && $stable(state_r.sticky.header)) else $error("masked error logged");
  a_header_capture: assert property (err_event_i.valid && !err_event_i.masked && !hot_reset_i
    && !state_r.sticky.header_valid |=> state_r.sticky.header == $past(err_event_i.header)
    && state_r.sticky.first_error == $past(err_event_i.bit_index)) else $error("header not captured");
  a_first_held: assert property (state_r.sticky.header_valid |=> $stable(state_r.sticky.first_error))
    else $error("first error pointer moved");
  a_strap_count: assert property (!state_r.strap_taken && !hot_reset_i |=>
    state_r.chan.ext_count == {2'h0, $past(second_channel_strap_i)}) else $error("strap count wrong");
  a_strap_arb: assert property (!state_r.strap_taken && !hot_reset_i |=>
    state_r.chan.arb_cap == ($past(second_channel_strap_i) ? 8'h03 : 8'h00)) else $error("arb cap wrong");
  a_strap_offset: assert property (!state_r.strap_taken && !hot_reset_i |=>
    state_r.chan.arb_offset == ($past(second_channel_strap_i) ? 8'h03 : 8'h00)) else $error("offset wrong");
  a_autoload: assert property (state_r.strap_taken && autoload_valid_i && !hot_reset_i |=>
    state_r.chan == $past(autoload_i)) else $error("autoload ignored");
  a_arb_valid: assert property (arb_cap_valid_o == (state_r.chan.low_priority_channel_count != 3'h0))
    else $error("arb valid wrong");
  a_irq_level: assert property (irq_o == |(state_r.irq_status & state_r.irq_mask))
    else $error("irq level wrong");

  //------------------------------------------------------------
  // Register read checks
  //------------------------------------------------------------
  // pointer read back
  a_first_read: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_ERR_CAP_CTRL
    |=> rdata_o[4:0] == $past(state_r.sticky.first_error))
    else $error("first error pointer read wrong");
  a_enable_read: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_ERR_CAP_CTRL
    |=> rdata_o[6] == $past(state_r.sticky.gen_en) && rdata_o[8] == $past(state_r.sticky.chk_en))
    else $error("enable read wrong");
  a_hdr0_read: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_HDR_WORD0
    |=> rdata_o == $past(state_r.sticky.header[0]))
    else $error("header word zero wrong");
  a_hdr1_read: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_HDR_WORD1
    |=> rdata_o == $past(state_r.sticky.header[1]))
    else $error("header word one wrong");
  a_hdr2_read: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_HDR_WORD2
    |=> rdata_o == $past(state_r.sticky.header[2]))
    else $error("header word two wrong");
  a_hdr3_read: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_HDR_WORD3
    |=> rdata_o == $past(state_r.sticky.header[3]))
    else $error("header word three wrong");
  a_cap1_counts: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_PORT_CHAN_CAP1
    |=> rdata_o[2:0] == $past(state_r.chan.ext_count)
    && rdata_o[6:4] == $past(state_r.chan.low_priority_channel_count)) else $error("channel counts wrong");
  a_cap2_fields: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_PORT_CHAN_CAP2
    |=> rdata_o[7:0] == $past(state_r.chan.arb_cap) && rdata_o[31:24] == $past(state_r.chan.arb_offset))
    else $error("arbitration fields wrong");
  a_cap1_reserved: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_PORT_CHAN_CAP1
    |=> rdata_o[31:12] == 20'h00000 && !rdata_o[7] && !rdata_o[3])
    else $error("capability one reserved wrong");
  a_cap2_reserved: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_PORT_CHAN_CAP2
    |=> rdata_o[23:8] == 16'h0000)
    else $error("capability two reserved wrong");
  // Status read back
  a_status_read: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_IRQ_STATUS
    |=> rdata_o == {30'h00000000, $past(state_r.irq_status)})
    else $error("status read wrong");
  // Mask read back
  a_mask_read: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_IRQ_MASK
    |=> rdata_o == {30'h00000000, $past(state_r.irq_mask)})
    else $error("mask read wrong");
  // Idle read data zero
  a_rdata_idle: assert property (!req_i.rd
    |=> rdata_o == 32'h0000_0000)
    else $error("read data not idle");
  // Unmapped offset zero
  a_unmapped_zero: assert property (req_i.rd && req_i.addr == aer_vc_pkg::OFF_LOAD_CTRL
    |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  //------------------------------------------------------------
  // Error logging checks
  //------------------------------------------------------------
  // unmasked error messaged
  a_err_message: assert property (err_event_i.valid && !err_event_i.masked && !hot_reset_i
    |=> err_message_o)
    else $error("error message missing");
  a_err_quiet: assert property (!err_event_i.valid
    |=> !err_message_o)
    else $error("spurious error message");
  a_capture_locks: assert property (err_event_i.valid && !err_event_i.masked && !hot_reset_i
    |=> state_r.sticky.header_valid)
    else $error("capture lock not set");
  a_header_lock: assert property (state_r.sticky.header_valid
    |=> $stable(state_r.sticky.header))
    else $error("locked header changed");
  a_hot_keeps_log: assert property (hot_reset_i && !err_event_i.valid
    |=> $stable(state_r.sticky.header) && $stable(state_r.sticky.first_error))
    else $error("header log lost on hot reset");

  //------------------------------------------------------------
  // Interrupt checks
  //------------------------------------------------------------
  // Captured event sets status
  a_status_capture: assert property (err_event_i.valid && !err_event_i.masked && !hot_reset_i
    && !state_r.sticky.header_valid |=> state_r.irq_status[aer_vc_pkg::IRQ_HDR_CAPTURED])
    else $error("capture status not set");
  // Dropped event sets status
  a_status_dropped: assert property (err_event_i.valid && err_event_i.masked && !hot_reset_i
    |=> state_r.irq_status[aer_vc_pkg::IRQ_HDR_DROPPED])
    else $error("dropped status not set");
  // Write one clears status
  a_status_clear: assert property (req_i.wr && req_i.addr == aer_vc_pkg::OFF_IRQ_STATUS && !err_event_i.valid
    |=> (state_r.irq_status & $past(req_i.wdata[1:0])) == 2'h0)
    else $error("status not cleared");
  // Status holds without cause
  a_status_sticky: assert property (!err_event_i.valid && !hot_reset_i
    && !(req_i.wr && req_i.addr == aer_vc_pkg::OFF_IRQ_STATUS) |=> $stable(state_r.irq_status))
    else $error("status changed without cause");
  // Mask write lands
  a_mask_write: assert property (req_i.wr && req_i.addr == aer_vc_pkg::OFF_IRQ_MASK && !hot_reset_i
    |=> state_r.irq_mask == $past(req_i.wdata[1:0]))
    else $error("mask write lost");
  // Interrupt needs mask
  a_irq_needs_mask: assert property (irq_o
    |-> state_r.irq_mask != 2'h0)
    else $error("interrupt with all masked");

  //------------------------------------------------------------
  // Reset and hold checks
  //------------------------------------------------------------
  // enables hold
  a_enable_hold: assert property (!(req_i.wr && req_i.addr == aer_vc_pkg::OFF_ERR_CAP_CTRL)
    |=> $stable(ecrc_gen_en_o) && $stable(ecrc_chk_en_o))
    else $error("enable changed without write");
  a_chan_hold: assert property (state_r.strap_taken && !autoload_valid_i && !hot_reset_i
    |=> $stable(state_r.chan))
    else $error("channel fields changed");
  a_arb_valid_load: assert property (state_r.strap_taken && autoload_valid_i && !hot_reset_i
    |=> arb_cap_valid_o == ($past(autoload_i.low_priority_channel_count) != 3'h0))
    else $error("arb valid not updated");
  a_strap_first: assert property (!state_r.strap_taken && autoload_valid_i && !hot_reset_i
    |=> $stable(state_r.chan.low_priority_channel_count))
    else $error("autoload taken in strap cycle");
  a_hot_resample: assert property (hot_reset_i
    |=> !state_r.strap_taken)
    else $error("strap not resampled");
  a_strap_once: assert property (state_r.strap_taken && !hot_reset_i
    |=> state_r.strap_taken)
    else $error("strap sampled again");
  a_hot_quiet: assert property (hot_reset_i
    |=> rdata_o == 32'h0000_0000 && !err_message_o && !irq_o && state_r.irq_status == 2'h0
    && state_r.irq_mask == aer_vc_pkg::IRQ_MASK_RESET) else $error("hot reset left state");

  c_capture: cover property (err_event_i.valid && !err_event_i.masked ##1 irq_o);
  c_clear: cover property (irq_o ##1 req_i.wr && req_i.addr == aer_vc_pkg::OFF_IRQ_STATUS ##1 !irq_o);
  c_masked: cover property (err_event_i.valid && err_event_i.masked);
  c_hot_reset: cover property (ecrc_gen_en_o ##1 hot_reset_i ##1 ecrc_gen_en_o);
  c_autoload: cover property (state_r.strap_taken && autoload_valid_i);

endmodule : aer_ecrc_channel_capability_header_regs

// [sim/tb_top.sv]
// Self-checking testbench for the error and channel capability register bank
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hot_reset_i = 1'b0;
  logic second_channel_strap_i = 1'b1;
  logic autoload_valid_i = 1'b0;
  aer_vc_pkg::chan_cap_s autoload_i = '0;
  aer_vc_pkg::err_event_s err_event_i = '0;
  aer_vc_pkg::reg_req_s req_i = '0;
  logic [31:0] rdata_o;
  logic ecrc_gen_en_o, ecrc_chk_en_o, err_message_o, arb_cap_valid_o, irq_o;
  int n_fail = 0;
  int check_count = 0;
  logic [127:0] hdr = 128'h00112233_44556677_8899AABB_CCDDEEFF;

  aer_ecrc_channel_capability_header_regs aer_ecrc_channel_capability_header_regs_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .hot_reset_i(hot_reset_i),
    .second_channel_strap_i(second_channel_strap_i), .autoload_valid_i(autoload_valid_i),
    .autoload_i(autoload_i), .err_event_i(err_event_i), .req_i(req_i), .rdata_o(rdata_o),
    .ecrc_gen_en_o(ecrc_gen_en_o), .ecrc_chk_en_o(ecrc_chk_en_o), .err_message_o(err_message_o),
    .arb_cap_valid_o(arb_cap_valid_o), .irq_o(irq_o));

  always #5 ref_clk_i = ~ref_clk_i;

  //------------------------------------------------------------
  // Shared tasks
  //------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    req_i <= '0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    req_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    req_i <= '0;
    #1;
    chk($sformatf("read %h", a), rdata_o, exp);
  endtask : rd

  task automatic fire(input logic [4:0] idx, input logic msk, input logic [127:0] h);
    @(posedge ref_clk_i);
    err_event_i <= '{valid: 1'b1, bit_index: idx, masked: msk, header: h};
    @(posedge ref_clk_i);
    err_event_i <= '0;
    #1;
    chk("error message", {31'h0, err_message_o}, {31'h0, ~msk});
  endtask : fire

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  //------------------------------------------------------------
  // Scenarios
  //------------------------------------------------------------
  task automatic t_reset_values();
    rd(12'h118, 32'h0000_00A0);
    rd(12'h140, 32'h20C1_0002);
    rd(12'h144, 32'h0000_0801);
    rd(12'h148, 32'h0300_0003);
    chk("arb valid", {31'h0, arb_cap_valid_o}, 32'h0);
    $display("test reset values done");
  endtask : t_reset_values

  task automatic t_enables();
    wr(12'h118, 32'hFFFF_FFFF);
    #1;
    chk("gen and chk enables", {30'h0, ecrc_chk_en_o, ecrc_gen_en_o}, 32'h3);
    rd(12'h118, 32'h0000_01E0);
    wr(12'h118, 32'h0000_0040);
    rd(12'h118, 32'h0000_00E0);
    wr(12'h144, 32'hFFFF_FFFF);
    rd(12'h144, 32'h0000_0801);
    $display("test enables done");
  endtask : t_enables

  task automatic t_error_log();
    wr(12'h164, 32'h0000_0003);
    fire(5'h0C, 1'b1, ~hdr);
    rd(12'h11C, 32'h0);
    fire(5'h12, 1'b0, hdr);
    fire(5'h07, 1'b0, ~hdr);
    rd(12'h118, 32'h0000_00F2);
    rd(12'h11C, hdr[31:0]);
    rd(12'h120, hdr[63:32]);
    rd(12'h124, hdr[95:64]);
    rd(12'h128, hdr[127:96]);
    rd(12'h160, 32'h0000_0003);
    chk("irq raised", {31'h0, irq_o}, 32'h1);
    wr(12'h164, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    wr(12'h164, 32'h0000_0001);
    wr(12'h160, 32'h0000_0003);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
    rd(12'h1F0, 32'h0);
    $display("test error log done");
  endtask : t_error_log

  task automatic t_resets();
    @(posedge ref_clk_i);
    hot_reset_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    hot_reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rd(12'h118, 32'h0000_00F2);
    rd(12'h128, hdr[127:96]);
    rd(12'h164, 32'h0);
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    second_channel_strap_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rd(12'h118, 32'h0000_00A0);
    rd(12'h11C, 32'h0);
    rd(12'h144, 32'h0000_0800);
    rd(12'h148, 32'h0);
    $display("test resets done");
  endtask : t_resets

  task automatic t_autoload();
    @(posedge ref_clk_i);
    autoload_valid_i <= 1'b1;
    autoload_i <= '{ext_count: 3'h3, low_priority_channel_count: 3'h2, arb_cap: 8'h55, arb_offset: 8'h0A};
    @(posedge ref_clk_i);
    autoload_valid_i <= 1'b0;
    rd(12'h144, 32'h0000_0823);
    rd(12'h148, 32'h0A00_0055);
    chk("arb valid", {31'h0, arb_cap_valid_o}, 32'h1);
    $display("test autoload done");
  endtask : t_autoload

  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    t_reset_values();
    t_enables();
    t_error_log();
    t_resets();
    t_autoload();
    end_of_test();
  end

  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
endmodule : tb_top
